// *** rtl/adc_serial_pkg.sv ***
// Package with constants and types for the serial protocol select block.
package adc_serial_pkg;

  // ***************************************************************
  // Frame sizes and protocol codes
  // ***************************************************************
  localparam int unsigned CMD_BITS       = 22;
  localparam int unsigned OUT_BITS       = 22;
  localparam int unsigned FIFO_DEPTH     = 32;
  localparam int unsigned CNT_BITS       = 6;
  localparam logic [1:0]  MODE_00        = 2'h0;
  localparam logic [1:0]  MODE_01        = 2'h1;
  localparam logic [1:0]  MODE_10        = 2'h2;
  localparam logic [1:0]  MODE_11        = 2'h3;
  localparam logic [1:0]  OUT_STANDARD   = 2'h0;
  localparam logic [1:0]  OUT_EARLY      = 2'h1;
  localparam logic [1:0]  OUT_SOURCE_CLK = 2'h3;
  localparam logic [1:0]  SYNC_ECHO      = 2'h0;
  localparam logic [1:0]  RESET_IN_MODE  = 2'h0;
  localparam logic [1:0]  RESET_OUT_SEL  = 2'h0;

  // Protocol selection applied to one frame.
  typedef struct packed {
    logic [1:0] inputClockMode;
    logic [1:0] outputProtocolSelect;
    logic [1:0] syncClockSourceSelect;
  } protocol_type;

  // Pin inputs after synchronisation.
  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } pins_type;

endpackage : adc_serial_pkg

// *** rtl/adc_serial_protocol_select.sv ***
// Serial interface frame handling with result FIFO and protocol selection.
//
// Summary of operation
// - Zone-2 source-clock mode uses only echo clock; code still runs other sources and raises sourceClockFault.
// - Launch and capture on opposite SCLK edges.
// - Source-clock mode drives strobe clock with data.
// - Four input clock modes for command writes.
// - Write needs at least 22 capture edges.
// - Reset selects mode 00 for reads, writes.
// - Writes follow input clock mode always.
// - MSB launch edge depends on clock mode.
// - Early launch only in input modes 00, 10.
// - Early launch drives bits half period sooner.
// - Ready strobe low through legacy frames.
// - Long legacy frames daisy-chain shifted-in bits out.
// - Short frame leaves command register unchanged.
// - Long frame keeps last 22 bits.
// - Chip select high releases lane, hands command.

// *****************************************************************
// Timing overview
// *****************************************************************
// Every pin passes two flip-flops and one edge detector, so the logic
// acts on a pin change three clock cycles after it happens. The link
// clock must therefore stay well below a quarter of the system clock.
// The lane output adds one more flop, so a launched bit reaches the pin
// four cycles after the link edge that launched it. The host samples on
// the opposite edge, half a link period later, which leaves room for it.
//
// Chip select falling loads the next result from the FIFO into the
// output shift register. An empty FIFO loads zeros, so a host that reads
// too soon sees a zero word rather than a stale one.
//
// In modes 01 and 11 the first launch edge carries the MSB that already
// sits on the lane, so that edge does not shift. In modes 00 and 10 the
// MSB is on the lane from chip select fall and every launch edge shifts.
//
// Early launch shifts on the capture edge instead of the launch edge.
// The host samples the old bit at that edge, and the new one follows a
// few cycles later, half a link period sooner than in standard mode.
//
// A protocol selection is staged and applied only at chip select fall.
// This keeps capture and launch edges steady for the whole frame, at the
// cost that a write made during a frame only acts on the next frame.
//
// The capture counter saturates at the command width, so frames of any
// length are accepted and only the last command word is kept. A frame
// that ends short of the count hands nothing on, and the stored command
// word stays as it was.
//
// Daisy chaining feeds the bit captured from the serial input into the
// tail of the output word, so a frame longer than the word passes the
// host's own bits back out. Outside the legacy selections the tail fills
// with zeros instead.
//
// The ready strobe is high between frames. In the legacy selections it
// is low for the whole frame; in source-clock mode it follows the link
// clock three cycles late, one cycle ahead of the data on the lane.
//
// Zone two is told by a port, since the conversion timing lives outside
// this block. A zone-two frame in source-clock mode with a source other
// than the clock echo raises a level fault; the lane still runs.

// *****************************************************************
// Result FIFO
// *****************************************************************
// The FIFO keeps results that arrive before the host reads them. Its
// ready output is combinational from the pointers, and its data output
// is read straight from the register array.
module adc_result_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              full  = (wrPtr[AW] != rdPtr[AW]) &&
                            (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire              empty = (wrPtr == rdPtr);
  wire              doWrite = inValid && !full;
  wire              doRead  = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = store[rdPtr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead)  rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule // adc_result_fifo

// *****************************************************************
// Frame and protocol logic
// *****************************************************************
module adc_serial_protocol_select
  import adc_serial_pkg::*;
#(
  parameter int unsigned WORD_BITS = OUT_BITS,
  parameter int unsigned DEPTH     = FIFO_DEPTH
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 csN,
  input  wire logic                 sclk,
  input  wire logic                 sdi,
  output      logic                 serialOutLane0,
  output      logic                 serialOutLane0En,
  output      logic                 readyStrobe,
  input  wire logic                 resultValid,
  output      logic                 resultReady,
  input  wire logic [WORD_BITS-1:0] resultData,
  input  wire logic [1:0]           nextInputClockMode,
  input  wire logic [1:0]           nextOutputProtocolSelect,
  input  wire logic [1:0]           nextSyncClockSourceSelect,
  input  wire logic                 protocolWrite,
  input  wire logic                 zoneTwo,
  output      logic [1:0]           inputClockMode,
  output      logic [1:0]           outputProtocolSelect,
  output      logic                 sourceClockFault,
  output      logic [CMD_BITS-1:0]  commandShiftRegister,
  output      logic                 commandValid
);
  // Pin synchronisers: stage one is read only by stage two.
  pins_type pinMeta;
  pins_type pins;
  pins_type pinsPrev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinMeta  <= '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
      pins     <= '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
      pinsPrev <= '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
    end else begin
      pinMeta  <= '{csN: csN, sclk: sclk, sdi: sdi};
      pins     <= pinMeta;
      pinsPrev <= pins;
    end
  end

  wire csFall   = pinsPrev.csN && !pins.csN;
  wire csRise   = !pinsPrev.csN && pins.csN;
  wire inFrame  = !pins.csN;
  wire sclkRise = inFrame && !pinsPrev.sclk && pins.sclk;
  wire sclkFall = inFrame && pinsPrev.sclk && !pins.sclk;

  // Modes 00 and 11 capture on the rising edge, 01 and 10 on falling.
  function automatic logic capture_on_rise(input logic [1:0] mode);
    return (mode == MODE_00) || (mode == MODE_11);
  endfunction

  // Pending selection is staged and only applied at a frame start.
  protocol_type pending;
  protocol_type active;
  // A frame that starts in this cycle is already governed by the staged
  // choice, so its first decisions never use the previous frame's mode.
  protocol_type frameSel;

  assign frameSel = csFall ? pending : active;

  wire captureRising = capture_on_rise(frameSel.inputClockMode);
  wire captureEdge   = captureRising ? sclkRise : sclkFall;
  wire launchEdge    = captureRising ? sclkFall : sclkRise;
  // Early launch only counts in input modes 00 and 10.
  wire earlyOn = (frameSel.outputProtocolSelect == OUT_EARLY) &&
                 !frameSel.inputClockMode[0];
  wire legacyOut = (frameSel.outputProtocolSelect == OUT_STANDARD) ||
                   (frameSel.outputProtocolSelect == OUT_EARLY);
  wire sourceClk = (frameSel.outputProtocolSelect == OUT_SOURCE_CLK);
  // MSB sits on the lane at chip select fall in modes 00 and 10.
  wire msbAtCs   = !frameSel.inputClockMode[0];
  wire earlyEdge = captureEdge; // Early launch moves to the capture edge.
  wire shiftOut  = earlyOn ? earlyEdge : launchEdge;

  logic [WORD_BITS-1:0] outShift;
  logic [CMD_BITS-1:0]  cmdShift;
  logic [CNT_BITS-1:0]  edgeCount;
  logic                 firstLaunch;
  logic                 fifoValid;
  logic [WORD_BITS-1:0] fifoData;
  wire                  fifoTake = csFall && fifoValid;
  // Daisy bits come from the capture path, so the bit placed for a
  // capture edge is the one passed on, whichever edge launches it.
  wire                  daisyBit = earlyOn ? pins.sdi : cmdShift[0];
  wire                  fillBit  = legacyOut ? daisyBit : 1'b0;

  adc_result_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(DEPTH)
  ) resultFifo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .inValid (resultValid),
    .inReady (resultReady),
    .inData  (resultData),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData (fifoData)
  );

  wire countFull = (edgeCount >= CNT_BITS'(CMD_BITS));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending <= '{RESET_IN_MODE, RESET_OUT_SEL, SYNC_ECHO};
      active  <= '{RESET_IN_MODE, RESET_OUT_SEL, SYNC_ECHO};
    end else begin
      if (protocolWrite) begin
        pending <= '{nextInputClockMode, nextOutputProtocolSelect,
                     nextSyncClockSourceSelect};
      end
      if (csFall) active <= pending;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmdShift  <= '0;
      edgeCount <= '0;
    end else if (csFall) begin
      edgeCount <= '0;
    end else if (captureEdge) begin
      cmdShift  <= {cmdShift[CMD_BITS-2:0], pins.sdi};
      if (!countFull) edgeCount <= edgeCount + 1'b1;
    end
  end

  // In the legacy selections, shifted-in bits enter the output word tail for daisy chaining; otherwise zeros enter.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outShift    <= '0;
      firstLaunch <= 1'b0;
    end else if (csFall) begin
      outShift    <= fifoValid ? fifoData : '0;
      firstLaunch <= !msbAtCs && !earlyOn;
    end else if (shiftOut) begin
      if (firstLaunch) begin
        firstLaunch <= 1'b0;
      end else begin
        outShift <= {outShift[WORD_BITS-2:0], fillBit};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      commandShiftRegister <= '0;
      commandValid         <= 1'b0;
    end else begin
      commandValid <= csRise && countFull;
      if (csRise && countFull) begin
        commandShiftRegister <= cmdShift;
      end
    end
  end

  // Lane and strobe outputs are registered.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serialOutLane0   <= 1'b0;
      serialOutLane0En <= 1'b0;
      readyStrobe      <= 1'b1;
      sourceClockFault <= 1'b0;
    end else begin
      serialOutLane0   <= outShift[WORD_BITS-1];
      serialOutLane0En <= inFrame && !csRise;
      // Strobe echoes SCLK in source-clock mode, else low in frame.
      readyStrobe      <= inFrame ? (sourceClk && pins.sclk)
                                  : 1'b1;
      sourceClockFault <= zoneTwo && sourceClk &&
                          (frameSel.syncClockSourceSelect != SYNC_ECHO);
    end
  end

  assign inputClockMode       = active.inputClockMode;
  assign outputProtocolSelect = active.outputProtocolSelect;
endmodule // adc_serial_protocol_select

// *** tb/adc_serial_props.sv ***
// Checker with port properties of the protocol select block.
module adc_serial_props
  import adc_serial_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                csN,
  input wire logic                sclk,
  input wire logic                zoneTwo,
  input wire logic                serialOutLane0En,
  input wire logic                readyStrobe,
  input wire logic [1:0]          inputClockMode,
  input wire logic [1:0]          outputProtocolSelect,
  input wire logic                sourceClockFault,
  input wire logic [CMD_BITS-1:0] commandShiftRegister,
  input wire logic                commandValid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Five samples cover the two-flop synchroniser, detect and output flop.
  sequence s_idle; csN [*5]; endsequence
  sequence s_calm; !zoneTwo [*3]; endsequence
  property p_reset_mode; $fell(rst) |->
    {inputClockMode, outputProtocolSelect} == {RESET_IN_MODE, RESET_OUT_SEL};
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("selection not default after reset");
  property p_idle_lane; s_idle |-> !serialOutLane0En; endproperty
  a_idle_lane: assert property (p_idle_lane)
    else $error("lane driven outside frame");
  property p_idle_strobe;
    s_idle ##0 outputProtocolSelect != OUT_SOURCE_CLK |-> readyStrobe;
  endproperty
  a_idle_strobe: assert property (p_idle_strobe)
    else $error("strobe low outside frame");
  property p_frame_strobe; serialOutLane0En
    && outputProtocolSelect != OUT_SOURCE_CLK |-> !readyStrobe;
  endproperty
  a_frame_strobe: assert property (p_frame_strobe)
    else $error("strobe high inside frame");
  property p_pulse; commandValid |-> !serialOutLane0En ##1 !commandValid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("command pulse wrong");
  property p_cmd_hold; !$stable(commandShiftRegister) |-> commandValid;
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command changed without pulse");
  property p_sel_hold;
    !$stable({inputClockMode, outputProtocolSelect})
      |-> $rose(serialOutLane0En);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("selection changed inside frame");
  property p_fault_calm; s_calm |-> !sourceClockFault; endproperty
  a_fault_calm: assert property (p_fault_calm)
    else $error("fault raised outside zone two");
  // Strobe follows the link clock three samples late in source-clock mode.
  property p_src_strobe;
    serialOutLane0En && $past(serialOutLane0En) &&
      outputProtocolSelect == OUT_SOURCE_CLK |-> readyStrobe == $past(sclk, 3);
  endproperty
  a_src_strobe: assert property (p_src_strobe)
    else $error("strobe does not echo link clock");
endmodule // adc_serial_props
bind adc_serial_protocol_select adc_serial_props adc_serial_props_inst (
  .ref_clk, .rst, .csN, .sclk, .zoneTwo, .serialOutLane0En, .readyStrobe,
  .inputClockMode, .outputProtocolSelect, .sourceClockFault,
  .commandShiftRegister, .commandValid);

// *** tb/host_model.sv ***
// Host controller model that frames, clocks and samples the serial pins.
module host_model (
  output logic     csN,
  output logic     sclk,
  output logic     sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Pin edges sit 37 ns off the clock edge so sampling never races it.
  task automatic frame(input logic [1:0] m, input int n,
                       input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    #37 sclk = m[1];
    #400 csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (!m[0]) sdi = tx[n-1-i];
      #400 sclk = ~sclk;
      if (m[0]) sdi = tx[n-1-i];
      else rx[n-1-i] = sdo;
      #400 sclk = ~sclk;
      if (m[0]) rx[n-1-i] = sdo;
    end
    #400 csN = 1'b1;
    // A released line flips so that a stale bit can never match.
    sdi = ~sdi;
  endtask
endmodule // host_model

// *** tb/test_adc_serial_protocol_select.sv ***
// Self-checking bench for the protocol select block.
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_adc_serial_protocol_select;
  import adc_serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                ref_clk = 1'b0, rst = 1'b1, resultValid = 1'b0;
  logic                csN, sclk, sdi, serialOutLane0, serialOutLane0En;
  logic                readyStrobe, resultReady, sourceClockFault;
  logic                commandValid, protocolWrite = 1'b0, zoneTwo = 1'b0;
  logic [OUT_BITS-1:0] resultData = '0;
  logic [1:0]          nextInputClockMode = '0, nextOutputProtocolSelect = '0;
  logic [1:0]          nextSyncClockSourceSelect = '0;
  logic [1:0]          inputClockMode, outputProtocolSelect;
  logic [CMD_BITS-1:0] commandShiftRegister, w, head, cmdQ[$], words[$];
  logic [63:0]         tx, rx, want;
  int                  n_mismatch = 0, total_checks = 0, seed = 32'hc291bc0e;
  int                  lens[3] = '{18, 22, 30};
  wire logic sdoSeen = serialOutLane0En ? serialOutLane0 : ~serialOutLane0;
  adc_serial_protocol_select adc_serial_protocol_select_inst (
    .ref_clk, .rst, .csN, .sclk, .sdi, .serialOutLane0, .serialOutLane0En,
    .readyStrobe, .resultValid, .resultReady, .resultData,
    .nextInputClockMode, .nextOutputProtocolSelect,
    .nextSyncClockSourceSelect, .protocolWrite, .zoneTwo, .inputClockMode,
    .outputProtocolSelect, .sourceClockFault, .commandShiftRegister,
    .commandValid);
  host_model host_model_inst (.csN, .sclk, .sdi, .sdo(sdoSeen));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (commandValid === 1'b1) begin
    if (cmdQ.size() == 0) `CHECK(1'b1, 1'b0)
    else begin
      head = cmdQ.pop_front();
      `CHECK(commandShiftRegister, head)
    end
  end
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic run(input logic [1:0] m, o, s, input int len);
    @(posedge ref_clk);
    tx = {$random(seed), $random(seed)};
    w = words.size() > 0 ? words.pop_front() : '0;
    want = '0;
    for (int i = 0; i < len; i++)
      want[len-1-i] = i < 22 ? w[21-i] : (o < 2'h2) & tx[len-1-(i-22)];
    if (len >= 22) cmdQ.push_back(tx[21:0]);
    nextInputClockMode <= m;
    nextOutputProtocolSelect <= o;
    nextSyncClockSourceSelect <= s;
    protocolWrite <= 1'b1;
    @(posedge ref_clk);
    protocolWrite <= 1'b0;
    host_model_inst.frame(m, len, tx, rx);
    if (o != OUT_SOURCE_CLK) `CHECK(rx, want)
    `CHECK(inputClockMode, m)
    for (int k = 0; k < 20 && cmdQ.size() > 0; k++) @(posedge ref_clk);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHECK(inputClockMode, MODE_00)
    resultValid <= 1'b1;
    resultData <= 22'($random(seed));
    repeat (40) begin
      @(posedge ref_clk);
      if (resultReady === 1'b1) begin
        words.push_back(resultData);
        resultData <= 22'($random(seed));
      end
    end
    resultValid <= 1'b0;
    `CHECK(words.size(), FIFO_DEPTH)
    for (int i = 0; i < 36; i++)
      run(2'(i % 4), 2'(i / 4 % 2), SYNC_ECHO, lens[i % 3]);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHECK(inputClockMode, MODE_00)
    zoneTwo <= 1'b1;
    run(MODE_00, OUT_SOURCE_CLK, 2'h1, 22);
    `CHECK(sourceClockFault, 1'b1)
    run(MODE_00, OUT_SOURCE_CLK, SYNC_ECHO, 22);
    `CHECK(sourceClockFault, 1'b0)
    final_report;
  end
  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end
endmodule // test_adc_serial_protocol_select
